// file: rtl/vectored_interrupt_controller.sv
`timescale 1ns/10ps
// Functional notes
// [R1] writing ones to the clear register drops those fast enable bits only
// [R2] software disables a source only in its handler or with peripheral off
// [R3] software never clears the enable of a source with a pending request
// [R4] fast status bit is raw fast signal AND fast enable
// [R5] set status bit means active fast request; plain mode has no vectoring
// [R6] programmed requests bypass masks and set status and raw together
// [R7] programmed bit 2 drives fast status and raw bit 1
// [R8] programmed bit 1 drives normal status and raw bit 1
// [R9] sources hold requests at least the minimum latency
// [R10] control bit 0 vectors normal sources, bit 1 vectors fast sources
// [R11] eight levels per type, sixteen when both types vectored
// [R12] fast request always beats a normal request
// [R13] each prioritised source takes a level 0 to 7 in 3-bit fields
// [R14] vector base holds 16 writable bits, upper half reads zero
// [R15] normal vector packs base, winning source index, zero low bits
// [R16] software reads normal vector only after a vectored normal interrupt
// [R17] first priority register holds levels for seven sources
// [R18] source 0 has no level; bits 3 to 0 reserved
// [R19] enabling a source as one type disables it as the other
// [R20] fast status bits 31 to 1 ORed into fast request and bit 0
// [R21] nesting status bit blocks its level and all lower levels
// [R22] equal levels resolve to the lower source number
// [R23] reserved bits read zero and ignore writes
module vectored_interrupt_controller
	import vic_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [vic_pkg::NUM_SRC-1:1] source_line,
	input wire logic [vic_pkg::NUM_SRC-1:0] normal_status,
	input wire logic [vic_pkg::NUM_SRC-1:1] normal_enable_set,
	input wire logic [vic_pkg::UPPER_SRCS*vic_pkg::LVL_W-1:0] upper_priority,
	input wire logic [vic_pkg::NUM_LVL-1:0] nesting_status,
	output logic fast_request,
	output logic normal_request,
	output logic fast_any,
	output logic normal_programmed,
	output logic [vic_pkg::NUM_SRC-1:1] normal_enable_drop,
	output logic vector_taken,
	output logic [vic_pkg::LVL_W-1:0] vector_level,
	output logic [vic_pkg::SRC_W-1:0] fast_top_source,
	output logic [vic_pkg::LVL_W-1:0] fast_top_level
);

	import vic_pkg::*;

	// bus phase capture
	logic take;
	logic valid_q;
	logic write_q;
	logic [31:0] addr_q;
	logic wr;
	logic rd_phase;

	// software state
	logic [BASE_W-1:0] vector_base;
	logic [31:0] priority_group_zero;
	logic [1:0] interrupt_control;
	logic [1:0] programmed_interrupt_config;
	logic [NUM_SRC-1:1] fast_enable_mask;
	logic [NUM_SRC-1:1] next_fast_enable_mask;

	// fast path
	logic [NUM_SRC-1:1] fast_raw_signal;
	logic [NUM_SRC-1:1] fast_status;
	logic fast_or;

	// prioritisation
	logic [NUM_SRC*LVL_W-1:0] levels;
	logic nfound;
	logic [SRC_W-1:0] nindex;
	logic [LVL_W-1:0] nlevel;
	logic ffound;
	logic [SRC_W-1:0] findex;
	logic [LVL_W-1:0] flevel;
	logic blocked;
	logic [31:0] read_mux;
	logic prog_fast;

	assign take = hsel && htrans[HTRANS_ACTIVE] && hready;
	assign wr = valid_q && write_q;
	assign rd_phase = valid_q && !write_q;
	assign prog_fast = programmed_interrupt_config[PROG_FAST_BIT-1];

	// address phase register, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_q <= 1'b0;
			write_q <= 1'b0;
			addr_q <= '0;
		end else begin
			valid_q <= take;
			if (take) begin
				write_q <= hwrite;
				addr_q <= haddr;
			end
		end
	end

	// slave ready from the first clock after reset, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
	end

	// vector base, only the low half stores
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_base <= RST_VECTOR_BASE;
		end else if (wr && addr_q == ADDR_VECTOR_BASE) begin
			vector_base <= hwdata[BASE_W-1:0]; // [R14]
		end
	end

	// first priority register, reserved bits dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			priority_group_zero <= RST_PRIORITY_GROUP_ZERO;
		end else if (wr && addr_q == ADDR_PRIORITY_GROUP_ZERO) begin
			priority_group_zero <= hwdata & PRIO0_MASK; // [R13] [R17] [R18] [R23]
		end
	end

	// vectoring enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			interrupt_control <= RST_INTERRUPT_CONTROL;
		end else if (wr && addr_q == ADDR_INTERRUPT_CONTROL) begin
			interrupt_control <= hwdata[CTRL_FAST_VEC:CTRL_NORMAL_VEC]; // [R10]
		end
	end

	// programmed requests, bits 2 and 1 only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			programmed_interrupt_config <= RST_PROG_CFG;
		end else if (wr && addr_q == ADDR_PROG_CFG) begin
			programmed_interrupt_config <= hwdata[PROG_FAST_BIT:PROG_NORMAL_BIT]; // [R23]
		end
	end

	// fast enable: set, clear, and cross-type exclusion
	always_comb begin
		next_fast_enable_mask = fast_enable_mask & ~normal_enable_set; // [R19]
		if (wr && addr_q == ADDR_FAST_ENABLE_MASK) begin
			next_fast_enable_mask = next_fast_enable_mask | hwdata[NUM_SRC-1:1];
		end
		if (wr && addr_q == ADDR_FAST_ENABLE_CLEAR) begin
			next_fast_enable_mask = next_fast_enable_mask & ~hwdata[NUM_SRC-1:1]; // [R1]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_enable_mask <= '0;
		end else begin
			fast_enable_mask <= next_fast_enable_mask;
		end
	end

	// fast enable writes knock out the normal enable of the same bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			normal_enable_drop <= '0;
		end else if (wr && addr_q == ADDR_FAST_ENABLE_MASK) begin
			normal_enable_drop <= hwdata[NUM_SRC-1:1]; // [R19]
		end else begin
			normal_enable_drop <= '0;
		end
	end

	// raw fast signal sampled from the sources plus programmed request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_raw_signal <= '0;
		end else begin
			fast_raw_signal <= source_line;
			fast_raw_signal[PROG_SRC] <= source_line[PROG_SRC] | prog_fast; // [R6] [R7]
		end
	end

	// enabled fast status; programmed bit is not maskable
	always_comb begin
		fast_status = fast_raw_signal & fast_enable_mask; // [R4]
		fast_status[PROG_SRC] = fast_status[PROG_SRC] | prog_fast; // [R6] [R7]
		fast_or = |fast_status; // [R20]
	end

	// level table: source 0 fixed, group zero, then upper sources
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_lvl
			if (g == 0) begin : g_src0
				assign levels[g*LVL_W +: LVL_W] = '0; // [R18]
			end else if (g <= GROUP0_SRCS) begin : g_grp0
				assign levels[g*LVL_W +: LVL_W] =
					priority_group_zero[g*PRIO_STEP +: LVL_W]; // [R13] [R17]
			end else begin : g_upper
				assign levels[g*LVL_W +: LVL_W] =
					upper_priority[(g-GROUP0_SRCS-1)*LVL_W +: LVL_W];
			end
		end
	endgenerate

	// winner among active normal sources
	priority_select u_normal_sel (
		.active(normal_status),
		.levels(levels),
		.found(nfound),
		.index(nindex),
		.level(nlevel)
	);

	// winner among active fast sources, combined bit excluded
	priority_select u_fast_sel (
		.active({fast_status, 1'b0}),
		.levels(levels),
		.found(ffound),
		.index(findex),
		.level(flevel)
	);

	// nesting block: winner level or any higher level in service
	always_comb begin
		blocked = 1'b0;
		for (int j = 0; j < NUM_LVL; j++) begin
			if (nesting_status[j] && LVL_W'(j) <= nlevel) begin
				blocked = 1'b1; // [R21]
			end
		end
	end

	// requests to the core; fast masks normal
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_request <= 1'b0;
			fast_any <= 1'b0;
			normal_request <= 1'b0;
		end else begin
			fast_request <= fast_or; // [R5] [R20]
			fast_any <= fast_or; // [R20]
			normal_request <= nfound && !fast_or && // [R12] [R11]
				!(interrupt_control[CTRL_NORMAL_VEC] && blocked); // [R21]
		end
	end

	// programmed normal request handed to the normal registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			normal_programmed <= 1'b0;
		end else begin
			normal_programmed <= programmed_interrupt_config[PROG_NORMAL_BIT-1]; // [R8]
		end
	end

	// fast winner only reported when fast vectoring is on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_top_source <= '0;
			fast_top_level <= '0;
		end else if (interrupt_control[CTRL_FAST_VEC] && ffound) begin
			fast_top_source <= findex; // [R10] [R22]
			fast_top_level <= flevel; // [R11]
		end else begin
			fast_top_source <= '0;
			fast_top_level <= '0;
		end
	end

	// vector read tells the nesting logic which level entered service
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_taken <= 1'b0;
			vector_level <= '0;
		end else if (take && !hwrite && haddr == ADDR_NORMAL_VECTOR &&
				interrupt_control[CTRL_NORMAL_VEC] && nfound) begin
			vector_taken <= 1'b1;
			vector_level <= nlevel;
		end else begin
			vector_taken <= 1'b0;
		end
	end

	// read multiplexer, unmapped reads zero
	always_comb begin
		read_mux = '0;
		case (haddr)
			ADDR_PROG_CFG: begin
				read_mux[PROG_FAST_BIT:PROG_NORMAL_BIT] = programmed_interrupt_config;
			end
			ADDR_VECTOR_BASE: begin
				read_mux[BASE_W-1:0] = vector_base; // [R14]
			end
			ADDR_NORMAL_VECTOR: begin
				read_mux[VEC_BASE_LSB +: BASE_W] = vector_base; // [R15]
				read_mux[VEC_IDX_LSB +: SRC_W] = nindex; // [R15] [R22]
			end
			ADDR_PRIORITY_GROUP_ZERO: begin
				read_mux = priority_group_zero;
			end
			ADDR_INTERRUPT_CONTROL: begin
				read_mux[CTRL_FAST_VEC:CTRL_NORMAL_VEC] = interrupt_control;
			end
			ADDR_FAST_STATUS: begin
				read_mux[NUM_SRC-1:0] = {fast_status, fast_or}; // [R4] [R20]
			end
			ADDR_FAST_RAW_SIGNAL: begin
				read_mux[NUM_SRC-1:0] = {fast_raw_signal, fast_or}; // [R20]
			end
			ADDR_FAST_ENABLE_MASK: begin
				read_mux[NUM_SRC-1:1] = fast_enable_mask;
			end
			default: begin
				read_mux = '0; // [R1] [R23]
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (take && !hwrite) begin
			hrdata <= read_mux;
		end
	end

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	clear_mask_a: assert property ( // [R1]
		wr && addr_q == ADDR_FAST_ENABLE_CLEAR |=>
			(fast_enable_mask & $past(hwdata[NUM_SRC-1:1])) == '0)
		else $error("fast enable bit survived a clear write");

	exclusive_a: assert property ( // [R19]
		|normal_enable_set && !wr |=>
			(fast_enable_mask & $past(normal_enable_set)) == '0)
		else $error("source enabled as both types");

	prog_fast_a: assert property ( // [R7]
		wr && addr_q == ADDR_PROG_CFG && hwdata[PROG_FAST_BIT] |-> ##[1:3] fast_request)
		else $error("programmed fast request not raised");

	prog_normal_a: assert property ( // [R8]
		wr && addr_q == ADDR_PROG_CFG |-> ##2 normal_programmed == $past(hwdata[PROG_NORMAL_BIT], 2))
		else $error("programmed normal request mismatch");

	fast_or_a: assert property ( // [R20]
		fast_or |=> fast_request && fast_any)
		else $error("fast status not ORed into request");

	precedence_a: assert property ( // [R12]
		normal_request |-> !fast_request)
		else $error("normal request alongside fast request");

	nest_block_a: assert property ( // [R21]
		interrupt_control[CTRL_NORMAL_VEC] && blocked |=> !normal_request)
		else $error("blocked level still requested");

	base_read_a: assert property ( // [R14]
		rd_phase && addr_q == ADDR_VECTOR_BASE |-> hrdata[31:BASE_W] == '0)
		else $error("vector base upper half not zero");

	vector_fmt_a: assert property ( // [R15]
		rd_phase && addr_q == ADDR_NORMAL_VECTOR |->
			hrdata[VEC_IDX_LSB-1:0] == '0 && hrdata[31:VEC_TOP_ZERO] == '0 &&
			hrdata[VEC_IDX_LSB +: SRC_W] < SRC_W'(NUM_SRC))
		else $error("normal vector format broken");

	reserved_a: assert property ( // [R23]
		rd_phase && addr_q == ADDR_PRIORITY_GROUP_ZERO |-> (hrdata & ~PRIO0_MASK) == '0)
		else $error("reserved priority bits not zero");

endmodule

// file: rtl/vic_pkg.sv
package vic_pkg;

	// source and level geometry
	localparam int NUM_SRC = 22;
	localparam int SRC_W = 5;
	localparam int LVL_W = 3;
	localparam int NUM_LVL = 8;
	localparam int GROUP0_SRCS = 7;
	localparam int UPPER_SRCS = NUM_SRC - 1 - GROUP0_SRCS;
	localparam int PRIO_STEP = 4;
	localparam int BASE_W = 16;

	// register byte addresses
	localparam logic [31:0] ADDR_PROG_CFG = 32'hFFFF0010;
	localparam logic [31:0] ADDR_VECTOR_BASE = 32'hFFFF0014;
	localparam logic [31:0] ADDR_NORMAL_VECTOR = 32'hFFFF001C;
	localparam logic [31:0] ADDR_PRIORITY_GROUP_ZERO = 32'hFFFF0020;
	localparam logic [31:0] ADDR_INTERRUPT_CONTROL = 32'hFFFF0030;
	localparam logic [31:0] ADDR_FAST_STATUS = 32'hFFFF0100;
	localparam logic [31:0] ADDR_FAST_RAW_SIGNAL = 32'hFFFF0104;
	localparam logic [31:0] ADDR_FAST_ENABLE_MASK = 32'hFFFF0108;
	localparam logic [31:0] ADDR_FAST_ENABLE_CLEAR = 32'hFFFF010C;

	// reset values
	localparam logic [BASE_W-1:0] RST_VECTOR_BASE = 16'h0000;
	localparam logic [31:0] RST_PRIORITY_GROUP_ZERO = 32'h00000000;
	localparam logic [1:0] RST_INTERRUPT_CONTROL = 2'h0;
	localparam logic [1:0] RST_PROG_CFG = 2'h0;

	// writable bits of the first priority register
	localparam logic [31:0] PRIO0_MASK = 32'h77777770;

	// field positions
	localparam int CTRL_NORMAL_VEC = 0;
	localparam int CTRL_FAST_VEC = 1;
	localparam int PROG_NORMAL_BIT = 1;
	localparam int PROG_FAST_BIT = 2;
	localparam int PROG_SRC = 1;
	localparam int VEC_IDX_LSB = 2;
	localparam int VEC_BASE_LSB = 7;
	localparam int VEC_TOP_ZERO = 23;
	localparam int HTRANS_ACTIVE = 1;

	localparam logic HRESP_OKAY = 1'b0;

endpackage

// file: rtl/priority_select.sv
`timescale 1ns/10ps
module priority_select
	import vic_pkg::*;
(
	input wire logic [vic_pkg::NUM_SRC-1:0] active,
	input wire logic [vic_pkg::NUM_SRC*vic_pkg::LVL_W-1:0] levels,
	output logic found,
	output logic [vic_pkg::SRC_W-1:0] index,
	output logic [vic_pkg::LVL_W-1:0] level
);

	// lowest level wins; scanning downward makes ties go to the lower source
	always_comb begin
		found = 1'b0;
		index = '0;
		level = '1;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (active[i] && (!found || levels[i*LVL_W +: LVL_W] <= level)) begin
				found = 1'b1;
				index = SRC_W'(i);
				level = levels[i*LVL_W +: LVL_W];
			end
		end
	end

endmodule

// file: testbench/peripheral_sources.sv
`timescale 1ns/10ps
module peripheral_sources
	import vic_pkg::*;
#(
	parameter int MIN_HOLD = 4
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [vic_pkg::NUM_SRC-1:1] want,
	output logic [vic_pkg::NUM_SRC-1:1] source_line
);
	int held;

	// a pattern stands its minimum time before the next one shows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			source_line <= '0;
			held <= 0;
		end else if (held + 1 >= MIN_HOLD && want != source_line) begin
			source_line <= want;
			held <= 0;
		end else if (held < MIN_HOLD) begin
			held <= held + 1;
		end
	end
endmodule

// file: testbench/vectored_interrupt_controller_bench.sv
`timescale 1ns/10ps
module vectored_interrupt_controller_bench;
	import vic_pkg::*;
	localparam int HOLD = 4;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, d, q, seed = 32'h213F;
	logic [31:0] m_en = '0, pm, base;
	logic [1:0] htrans = '0;
	logic hready, hresp, freq, nreq, fany, nprog, vtak, vt_seen = 1'b0;
	logic [NUM_SRC-1:1] want = '0, lines, ne_set = '0, drop, drop_seen = '0, m_drop = '0;
	logic [NUM_SRC-1:0] nstat = '0;
	logic [UPPER_SRCS*LVL_W-1:0] upper = '0;
	logic [NUM_LVL-1:0] nest = '0;
	logic [LVL_W-1:0] vlev, ftl;
	logic [SRC_W-1:0] fts;
	logic [31:0] ra [6];
	int errors = 0, n_compared = 0, w, wl;

	vectored_interrupt_controller dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.source_line(lines), .normal_status(nstat), .normal_enable_set(ne_set),
		.upper_priority(upper), .nesting_status(nest), .fast_request(freq),
		.normal_request(nreq), .fast_any(fany), .normal_programmed(nprog),
		.normal_enable_drop(drop), .vector_taken(vtak), .vector_level(vlev),
		.fast_top_source(fts), .fast_top_level(ftl));

	peripheral_sources #(.MIN_HOLD(HOLD)) src_u (.hclk(hclk), .hresetn(hresetn),
		.want(want), .source_line(lines));

	// clock and drop pulse collector
	always #5 hclk = ~hclk;
	always @(posedge hclk) drop_seen <= drop_seen | drop;
	always @(posedge hclk) vt_seen <= vt_seen | vtak;

	task automatic finish_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wt;
		for (int i = 0; i < 20; i++) begin
			@(posedge hclk);
			if (hready === 1'b1) return;
		end
		errors++;
		finish_test();
	endtask

	// one single transfer: address phase, then data phase
	task automatic bus(input logic [31:0] a, input logic [31:0] v, input logic wr);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		wt();
		htrans <= 2'h0;
		hwdata <= v;
		wt();
		q = hrdata;
	endtask

	task automatic rc(input logic [31:0] a, input logic [31:0] e, input string n);
		bus(a, '0, 1'b0);
		chk(n, e, q);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// reference status: raw AND enable, programmed bit 1, bit 0 the OR
	function automatic logic [31:0] fstat(input logic [NUM_SRC-1:1] ln, input logic pf);
		logic [31:0] s;
		s = ({10'h0, ln, 1'b0} & m_en) | {30'h0, pf, 1'b0};
		return s | {31'h0, |s[31:1]};
	endfunction

	// reference winner: lowest level, lower source on a tie
	function automatic int win(input logic [NUM_SRC-1:0] ns, output int lv);
		int b, l;
		b = 0;
		lv = 8;
		for (int i = 0; i < NUM_SRC; i++) begin
			l = (i == 0) ? 0 : (i <= GROUP0_SRCS) ? int'(pm[4*i+:3]) : int'(upper[3*(i-8)+:3]);
			if (ns[i] && l < lv) begin
				b = i;
				lv = l;
			end
		end
		return b;
	endfunction

	initial begin
		ra = '{ADDR_VECTOR_BASE, ADDR_NORMAL_VECTOR, ADDR_PRIORITY_GROUP_ZERO,
			ADDR_FAST_STATUS, ADDR_FAST_ENABLE_CLEAR, 32'hFFFF0040};
		tick(5);
		hresetn <= 1'b1;
		tick(2);
		// reset values, write-only and unmapped places read zero
		foreach (ra[i]) rc(ra[i], 32'h0, "reset");
		bus(ADDR_VECTOR_BASE, 32'hFFFFFFFF, 1'b1);
		rc(ADDR_VECTOR_BASE, 32'h0000FFFF, "base");
		bus(ADDR_PRIORITY_GROUP_ZERO, 32'hFFFFFFFF, 1'b1);
		rc(ADDR_PRIORITY_GROUP_ZERO, 32'h77777770, "prio0");
		bus(ADDR_INTERRUPT_CONTROL, 32'hFFFFFFFF, 1'b1);
		rc(ADDR_INTERRUPT_CONTROL, 32'h3, "ctrl");
		// programmed requests ignore the masks
		bus(ADDR_PROG_CFG, 32'hFFFFFFFF, 1'b1);
		rc(ADDR_PROG_CFG, 32'h6, "prog");
		rc(ADDR_FAST_STATUS, fstat('0, 1'b1), "prog fast");
		chk("nprog", 1, nprog);
		chk("freq prog", 1, freq);
		chk("nreq prog", 0, nreq);
		bus(ADDR_PROG_CFG, 32'h0, 1'b1);
		tick(2);
		rc(ADDR_FAST_STATUS, 32'h0, "prog off");
		chk("nprog off", 0, nprog);
		// random enables and lines
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			d = seed & 32'h003FFFFE;
			bus(ADDR_FAST_ENABLE_MASK, d, 1'b1);
			m_en |= d;
			m_drop |= d[NUM_SRC-1:1];
			seed = lfsr(seed);
			want <= seed[NUM_SRC-1:1];
			tick(HOLD + 4);
			chk("drop", m_drop, drop_seen);
			rc(ADDR_FAST_STATUS, fstat(want, 1'b0), "fstat");
			chk("freq", |(fstat(want, 1'b0)), freq);
			chk("fany", |(fstat(want, 1'b0)), fany);
			want <= '0;
			tick(HOLD + 4);
			seed = lfsr(seed);
			bus(ADDR_FAST_ENABLE_CLEAR, seed, 1'b1);
			m_en &= ~seed;
			rc(ADDR_FAST_ENABLE_MASK, m_en, "clear");
			ne_set <= m_en[NUM_SRC-1:1];
			tick(1);
			ne_set <= '0;
			m_en = '0;
			tick(2);
			rc(ADDR_FAST_ENABLE_MASK, 32'h0, "cross");
		end
		// vectored normal sources
		bus(ADDR_INTERRUPT_CONTROL, 32'h1, 1'b1);
		seed = lfsr(seed);
		base = {16'h0, seed[15:0]};
		bus(ADDR_VECTOR_BASE, seed, 1'b1);
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			pm = seed & 32'h77777770;
			bus(ADDR_PRIORITY_GROUP_ZERO, seed, 1'b1);
			seed = lfsr(seed);
			upper <= {seed[9:0], seed};
			nstat <= seed[NUM_SRC-1:0] | 22'h200000;
			tick(3);
			w = win(nstat, wl);
			rc(ADDR_NORMAL_VECTOR, {9'h0, base[15:0], w[4:0], 2'h0}, "vector");
			tick(1);
			chk("vlevel", wl, vlev);
		end
		// nesting blocks the winner's level and below
		chk("vtaken", 1, vt_seen);
		chk("hresp", 0, hresp);
		chk("nreq", 1, nreq);
		nest <= 8'h1 << wl;
		tick(3);
		chk("nreq nest", 0, nreq);
		if (wl < 7) begin
			nest <= 8'h1 << (wl + 1);
			tick(3);
			chk("nreq low", 1, nreq);
		end
		nest <= '0;
		bus(ADDR_PROG_CFG, 32'h4, 1'b1);
		tick(3);
		chk("fast wins", 0, nreq);
		// fast winner reported only with fast vectoring on
		chk("ftop off", 0, fts);
		bus(ADDR_INTERRUPT_CONTROL, 32'h3, 1'b1);
		tick(2);
		chk("ftop", win(22'h2, wl), fts);
		chk("flevel", wl, ftl);
		finish_test();
	end
endmodule
